// ===== mmoc_defs.vh
// Register offsets, field positions and reset values of the motor output mode control block.
// Behaviour
// (RULE1) Output gate enable low tri-states all six outputs and stops controller clock.
// (RULE2) Writing soft-reset bit returns every controller register to reset state; code clears filt_r, currentComp and prdata only on rst_n.
// (RULE3) Sensor mode ignores step top bit; sensorless uses before and after behaviour.
// (RULE4) Without direct access, preloaded values become active at a commutation event.
// (RULE5) Direct access phase write drives outputs, loads all preloads, stops clock.
// (RULE6) Stopped clock keeps timer counter value; counter stays writable.
// (RULE7) Direct access outputs are static levels only, no PWM.
// (RULE8) Voltage/current select picks PWM step behaviour before demagnetization.
// (RULE9) Commutation type 1 makes compare register read-only to software.
// (RULE10) Current filter enable inserts filter in current comparator path.
// (RULE11) Compare loads weight times chosen capture divided by 32.
// (RULE12) Two-bit threshold field selects comparator reference level.
// (RULE13) Zero-cross edge select picks falling or rising edge; preloaded.
// (RULE14) Hardware and software demagnetization enables are preloaded until commutation.
// (RULE15) Only step top bit is preloaded; low step bits act immediately.
// (RULE16) Low step bits select even, odd, alternating or all channels after demag.
// (RULE17) Before demag, pattern follows voltage/current mode and top bit.
// (RULE18) Comparator input field routes phase A, B or C; code 11 unused.
// (RULE19) Channel on bits apply at commutation, or at once in direct access.
// (RULE20) Pin level combines polarity and channel on bit per output table.
// (RULE21) Reading a preloaded register returns the active value, not the preload.
// (RULE22) Registers are single word accesses; unused codes are ignored.
`ifndef MMOC_DEFS_VH
`define MMOC_DEFS_VH
`define MMOC_ADDR_TIM 12'h000
`define MMOC_ADDR_CMP 12'h004
`define MMOC_ADDR_WGT 12'h008
`define MMOC_ADDR_ZPRV 12'h00c
`define MMOC_ADDR_ZCUR 12'h010
`define MMOC_ADDR_CRA 12'h014
`define MMOC_ADDR_CRB 12'h018
`define MMOC_ADDR_PHS 12'h01c
`define MMOC_ADDR_POL 12'h020
`define MMOC_ADDR_STS 12'h024
`define MMOC_RST8 8'h00
`define MMOC_A_MOE 7
`define MMOC_A_RST 6
`define MMOC_A_SR 5
`define MMOC_A_DAC 4
`define MMOC_A_VC 3
`define MMOC_A_SWA 2
`define MMOC_A_CFF 1
`define MMOC_A_DCB 0
`define MMOC_B_CPB 5
`define MMOC_B_HDM 4
`define MMOC_B_SDM 3
`define MMOC_B_OS2 2
`define MMOC_DIV_SHIFT 5
`endif

// ===== mmoc_inverter_model.sv
// Inverter bridge model that turns the high-side gate levels into phase levels.
`timescale 1ns/100ps
module mmoc_inverter_model (
  input wire clk,
  input wire [5:0] pins,
  input wire [5:0] oe,
  output logic phaseA,
  output logic phaseB,
  output logic phaseC
);
  logic [2:0] last_r = 3'h0;
  always @(posedge clk) begin
    last_r <= {phaseC, phaseB, phaseA};
  end
  // A gate that is not driven floats, so its phase shows the inverse of its last level.
  assign phaseA = oe[0] ? pins[0] : ~last_r[0];
  assign phaseB = oe[2] ? pins[2] : ~last_r[1];
  assign phaseC = oe[4] ? pins[4] : ~last_r[2];
endmodule

// ===== mmoc_properties.sv
// Port checker of the motor output mode control block, bound to its top module.
`timescale 1ns/100ps
`include "mmoc_defs.vh"
module mmoc_properties (
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  input wire commutationEvent,
  input wire [5:0] motorOutputPins,
  input wire [5:0] motorOutputOe,
  input wire ctrlClockRun,
  input wire [1:0] referenceThresholdSelect,
  input wire zeroCrossEdgeSelect,
  input wire hwDemagEnable,
  input wire [7:0] commutationTimerCounter
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [1:0] thrW_r;
  wire wrDone = pready && pwrite;
  always @(posedge clk) begin
    if (wrDone) begin
      thrW_r <= pwdata[7:6];
    end
  end
  gate_clock_a: assert property (ctrlClockRun |-> motorOutputOe == 6'h3f)
    else $error("Controller clock runs while outputs are gated.");
  oe_whole_a: assert property (motorOutputOe == 6'h00 || motorOutputOe == 6'h3f)
    else $error("Output enables are split.");
  wait_state_a: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("Bus answer is not one wait state after setup.");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("Ready stands longer than one cycle.");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("Error response without ready.");
  timer_hold_a: assert property (!ctrlClockRun && !psel |=> $stable(commutationTimerCounter))
    else $error("Timer moved while the controller clock is stopped.");
  direct_static_a: assert property (motorOutputOe == 6'h3f && !ctrlClockRun && !psel
    && !$past(psel) |=> $stable(motorOutputPins))
    else $error("Output pins changed in direct access without a write.");
  soft_reset_a: assert property (wrDone && paddr == `MMOC_ADDR_CRA && pwdata[6] |-> ##2
    motorOutputOe == 6'h00 && referenceThresholdSelect == 2'h0 && !hwDemagEnable)
    else $error("Soft reset left controller state behind.");
  thr_now_a: assert property (wrDone && paddr == `MMOC_ADDR_CRB |=> ##[0:1]
    referenceThresholdSelect == thrW_r)
    else $error("Threshold field did not act at once.");
  preload_edge_a: assert property ($changed(zeroCrossEdgeSelect) |-> $past(commutationEvent)
    || $past(commutationEvent, 2) || $past(pready) || $past(pready, 2))
    else $error("Preloaded edge select changed without a commutation.");
  cover property (commutationEvent);
  cover property (pslverr);
  cover property (!ctrlClockRun && motorOutputOe == 6'h3f);
endmodule
bind mmoc_top mmoc_properties chk (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .commutationEvent(commutationEvent), .motorOutputPins(motorOutputPins),
  .motorOutputOe(motorOutputOe), .ctrlClockRun(ctrlClockRun),
  .referenceThresholdSelect(referenceThresholdSelect), .zeroCrossEdgeSelect(zeroCrossEdgeSelect),
  .hwDemagEnable(hwDemagEnable), .commutationTimerCounter(commutationTimerCounter));

// ===== mmoc_tb.sv
// Self-checking testbench of the motor output mode control block.
`timescale 1ns/100ps
`include "mmoc_defs.vh"
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, comEv = 1'b0, pwmLevel = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, compInput, ctrlClockRun, curComp, zce, hde, sde, phA, phB, phC;
  logic [5:0] pins, oe;
  logic [1:0] thr;
  logic [7:0] tmr;
  logic curRaw = 1'b0, capEv = 1'b0, demag = 1'b0, phOdd = 1'b0;
  logic [7:0] capVal = 8'h00;
  int error_cnt = 0, n_compared = 0;
  mmoc_top dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .commutationEvent(comEv), .pwmLevel(pwmLevel), .pwmPhaseOdd(phOdd), .demagDone(demag),
    .phaseInputA(phA), .phaseInputB(phB), .phaseInputC(phC), .currentCompRaw(curRaw),
    .captureValue(capVal), .captureEvent(capEv), .motorOutputPins(pins), .motorOutputOe(oe),
    .ctrlClockRun(ctrlClockRun), .compInput(compInput), .currentComp(curComp),
    .referenceThresholdSelect(thr), .zeroCrossEdgeSelect(zce), .hwDemagEnable(hde),
    .swDemagEnable(sde), .commutationTimerCounter(tmr));
  mmoc_inverter_model bridge (.clk(clk), .pins(pins), .oe(oe), .phaseA(phA), .phaseB(phB),
    .phaseC(phC));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      error_cnt++;
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n == 50) chk(32'h1, 32'h0, "bus timeout");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic t_reset_values();
    logic [11:0] regs[5];
    regs = '{`MMOC_ADDR_CRA, `MMOC_ADDR_CRB, `MMOC_ADDR_PHS, `MMOC_ADDR_POL, `MMOC_ADDR_TIM};
    foreach (regs[i]) begin
      apb(1'b0, regs[i], 32'h0);
      chk(rd, 32'h0, "reset value");
    end
    apb(1'b0, 12'h030, 32'h0);
    chk({31'h0, er}, 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped read");
  endtask
  task automatic t_preload();
    apb(1'b1, `MMOC_ADDR_CRA, 32'h80);
    apb(1'b1, `MMOC_ADDR_PHS, 32'h45);
    apb(1'b1, `MMOC_ADDR_CRB, 32'hff);
    tick(2);
    chk({zce, hde, sde, thr}, 32'h03, "config B before commutation");
    apb(1'b0, `MMOC_ADDR_CRB, 32'h0);
    chk(rd, 32'hc3, "active config B");
    chk(pins, 32'h3f, "pins before commutation");
    comEv <= 1'b1;
    @(posedge clk);
    comEv <= 1'b0;
    tick(3);
    chk({zce, hde, sde}, 32'h7, "config B after commutation");
    chk(pins, 32'h3a, "pins after commutation");
    chk(compInput, phB, "comparator input");
  endtask
  task automatic t_direct();
    apb(1'b1, `MMOC_ADDR_POL, 32'h3f);
    apb(1'b1, `MMOC_ADDR_CRA, 32'h90);
    apb(1'b1, `MMOC_ADDR_TIM, 32'h0);
    apb(1'b1, `MMOC_ADDR_PHS, 32'h0a);
    pwmLevel <= 1'b0;
    tick(8);
    chk({ctrlClockRun, oe}, 32'h3f, "direct access gating");
    chk(pins, 32'h0a, "direct pins");
    chk(tmr, 32'h0, "timer held");
    pwmLevel <= 1'b1;
  endtask
  task automatic t_compare_access();
    apb(1'b1, `MMOC_ADDR_CRA, 32'h04);
    apb(1'b1, `MMOC_ADDR_CMP, 32'h55);
    apb(1'b0, `MMOC_ADDR_CMP, 32'h0);
    chk(rd, 32'h0, "compare read only");
    chk(oe, 32'h0, "outputs tri-stated");
    apb(1'b1, `MMOC_ADDR_CRA, 32'h00);
    apb(1'b1, `MMOC_ADDR_CMP, 32'h55);
    apb(1'b0, `MMOC_ADDR_CMP, 32'h0);
    chk(rd, 32'h55, "compare writable");
  endtask
  task automatic t_soft_reset();
    apb(1'b1, `MMOC_ADDR_CRB, 32'hc0);
    apb(1'b1, `MMOC_ADDR_CRA, 32'hc0);
    tick(2);
    chk({oe, thr}, 32'h0, "outputs after soft reset");
    apb(1'b0, `MMOC_ADDR_CRA, 32'h0);
    chk(rd, 32'h0, "config A after soft reset");
    apb(1'b0, `MMOC_ADDR_CMP, 32'h0);
    chk(rd, 32'h0, "compare after soft reset");
  endtask
  task automatic t_capture();
    apb(1'b1, `MMOC_ADDR_CRA, 32'h85);
    apb(1'b1, `MMOC_ADDR_WGT, 32'h40);
    capVal <= 8'h20;
    capEv <= 1'b1;
    @(posedge clk);
    capEv <= 1'b0;
    apb(1'b0, `MMOC_ADDR_CMP, 32'h0);
    chk(rd, 32'h40, "compare from current capture");
    apb(1'b1, `MMOC_ADDR_CRA, 32'h84);
    capVal <= 8'h60;
    capEv <= 1'b1;
    @(posedge clk);
    capEv <= 1'b0;
    apb(1'b0, `MMOC_ADDR_CMP, 32'h0);
    chk(rd, 32'h40, "compare from previous capture");
    apb(1'b0, `MMOC_ADDR_ZPRV, 32'h0);
    chk(rd, 32'h20, "previous capture");
  endtask
  task automatic t_filter();
    apb(1'b1, `MMOC_ADDR_CRA, 32'h80);
    curRaw <= 1'b1;
    tick(2);
    chk(curComp, 32'h1, "unfiltered current comparator");
    curRaw <= 1'b0;
    apb(1'b1, `MMOC_ADDR_CRA, 32'h82);
    curRaw <= 1'b1;
    @(posedge clk);
    curRaw <= 1'b0;
    tick(4);
    chk(curComp, 32'h0, "filter blocks a glitch");
    curRaw <= 1'b1;
    tick(5);
    chk(curComp, 32'h1, "filter passes a steady level");
    curRaw <= 1'b0;
  endtask
  task automatic t_step();
    apb(1'b1, `MMOC_ADDR_CRA, 32'h88);
    apb(1'b1, `MMOC_ADDR_CRB, 32'h01);
    apb(1'b1, `MMOC_ADDR_PHS, 32'h3f);
    comEv <= 1'b1;
    pwmLevel <= 1'b0;
    @(posedge clk);
    comEv <= 1'b0;
    tick(3);
    chk(pins, 32'h15, "current mode chops even before demag");
    demag <= 1'b1;
    @(posedge clk);
    demag <= 1'b0;
    tick(3);
    chk(pins, 32'h2a, "odd chopping after demag");
    apb(1'b1, `MMOC_ADDR_CRB, 32'h02);
    tick(2);
    chk(pins, 32'h15, "alternate on even phase");
    phOdd <= 1'b1;
    tick(2);
    chk(pins, 32'h2a, "alternate on odd phase");
    phOdd <= 1'b0;
    pwmLevel <= 1'b1;
  endtask
  task automatic tally_and_finish();
    $display("Compared %0d values, %0d mismatches", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    forever #2 clk = ~clk;
  end
  initial begin
    tick(5000);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    tick(10);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset_values();
    t_preload();
    t_direct();
    t_compare_access();
    t_soft_reset();
    t_capture();
    t_filter();
    t_step();
    tally_and_finish();
  end
endmodule

// ===== mmoc_top.v
// Motor output mode control: configuration registers, preload logic and output pins.
`timescale 1ns/100ps
`include "mmoc_defs.vh"
module mmoc_top (
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire commutationEvent,
  input wire pwmLevel,
  input wire pwmPhaseOdd,
  input wire demagDone,
  input wire phaseInputA,
  input wire phaseInputB,
  input wire phaseInputC,
  input wire currentCompRaw,
  input wire [7:0] captureValue,
  input wire captureEvent,
  output reg [5:0] motorOutputPins,
  output reg [5:0] motorOutputOe,
  output reg ctrlClockRun,
  output reg compInput,
  output reg currentComp,
  output reg [1:0] referenceThresholdSelect,
  output reg zeroCrossEdgeSelect,
  output reg hwDemagEnable,
  output reg swDemagEnable,
  output reg [7:0] commutationTimerCounter
);

  reg [7:0] cfgA_r;
  reg [7:0] cfgBAct_r;
  reg [7:0] cfgBPre_r;
  reg [7:0] phsAct_r;
  reg [7:0] phsPre_r;
  reg [7:0] pol_r;
  reg [7:0] cmp_r;
  reg [7:0] wgt_r;
  reg [7:0] zPrv_r;
  reg [7:0] zCur_r;
  reg [2:0] filt_r;
  reg [5:0] pwmMask;
  reg [5:0] pinNxt;
  reg [31:0] rdNxt;
  reg beforeD;
  reg [1:0] pat;
  wire [15:0] product;
  wire [7:0] mulOperand;
  wire softReset;
  wire gateOn;
  wire direct;
  wire wrEn;
  wire rdEn;
  wire phsWrite;
  wire loadPre;
  wire addrOk;
  reg demag_r;

  localparam [1:0] PAT_EVEN = 2'b00;
  localparam [1:0] PAT_ODD = 2'b01;
  localparam [1:0] PAT_ALT = 2'b10;
  localparam [1:0] PAT_ALL = 2'b11;

  // Channel index 0 is taken as even; returns which active channels carry PWM.
  function [5:0] patMask;
    input [1:0] p;
    input odd;
    begin
      case (p)
        PAT_EVEN: patMask = 6'h15;
        PAT_ODD: patMask = 6'h2a;
        PAT_ALT: patMask = odd ? 6'h2a : 6'h15;
        default: patMask = 6'h3f;
      endcase
    end
  endfunction

  function isReg;
    input [11:0] a;
    begin
      isReg = (a == `MMOC_ADDR_TIM) || (a == `MMOC_ADDR_CMP) || (a == `MMOC_ADDR_WGT) ||
        (a == `MMOC_ADDR_ZPRV) || (a == `MMOC_ADDR_ZCUR) || (a == `MMOC_ADDR_CRA) ||
        (a == `MMOC_ADDR_CRB) || (a == `MMOC_ADDR_PHS) || (a == `MMOC_ADDR_POL) ||
        (a == `MMOC_ADDR_STS);
    end
  endfunction

  assign addrOk = isReg(paddr);
  assign wrEn = psel && penable && pwrite && pready;
  assign rdEn = psel && penable && !pwrite;
  assign softReset = wrEn && addrOk && (paddr == `MMOC_ADDR_CRA) && pwdata[`MMOC_A_RST]; // [RULE2]
  assign gateOn = cfgA_r[`MMOC_A_MOE];
  assign direct = cfgA_r[`MMOC_A_DAC];
  assign phsWrite = wrEn && (paddr == `MMOC_ADDR_PHS);
  assign loadPre = direct ? (phsWrite && gateOn) : commutationEvent; // [RULE4] [RULE5]
  // The arriving capture becomes the current value and the old current value the previous one.
  assign mulOperand = cfgA_r[`MMOC_A_DCB] ? captureValue : zCur_r; // [RULE11]
  assign product = wgt_r * mulOperand;

  // Register file, preload transfer and capture datapath.
  always @(posedge clk) begin
    if (!rst_n || softReset) begin // [RULE2]
      cfgA_r <= `MMOC_RST8;
      cfgBAct_r <= `MMOC_RST8;
      cfgBPre_r <= `MMOC_RST8;
      phsAct_r <= `MMOC_RST8;
      phsPre_r <= `MMOC_RST8;
      pol_r <= `MMOC_RST8;
      cmp_r <= `MMOC_RST8;
      wgt_r <= `MMOC_RST8;
      zPrv_r <= `MMOC_RST8;
      zCur_r <= `MMOC_RST8;
      commutationTimerCounter <= `MMOC_RST8;
      demag_r <= 1'b0;
    end else begin
      if (ctrlClockRun) begin
        commutationTimerCounter <= commutationTimerCounter + 8'h01;
      end
      if (captureEvent && ctrlClockRun) begin
        zPrv_r <= zCur_r;
        zCur_r <= captureValue;
      end
      // Autoswitched mode reloads the compare on each capture.
      if (captureEvent && ctrlClockRun && cfgA_r[`MMOC_A_SWA]) begin
        cmp_r <= product[7+`MMOC_DIV_SHIFT:`MMOC_DIV_SHIFT]; // [RULE11]
      end
      if (commutationEvent) begin
        demag_r <= 1'b0;
      end else if (demagDone) begin
        demag_r <= 1'b1;
      end
      if (loadPre) begin
        cfgBAct_r[7:2] <= cfgBPre_r[7:2]; // [RULE13] [RULE14] [RULE15]
        phsAct_r <= direct ? pwdata[7:0] : phsPre_r; // [RULE19]
      end
      if (wrEn) begin
        case (paddr)
          `MMOC_ADDR_TIM: commutationTimerCounter <= pwdata[7:0]; // [RULE6]
          `MMOC_ADDR_CMP: begin
            if (!cfgA_r[`MMOC_A_SWA]) begin
              cmp_r <= pwdata[7:0]; // [RULE9]
            end
          end
          `MMOC_ADDR_WGT: wgt_r <= pwdata[7:0];
          `MMOC_ADDR_ZPRV: zPrv_r <= pwdata[7:0];
          `MMOC_ADDR_ZCUR: zCur_r <= pwdata[7:0];
          `MMOC_ADDR_CRA: cfgA_r <= {pwdata[7], 1'b0, pwdata[5:0]};
          `MMOC_ADDR_CRB: begin
            cfgBPre_r <= pwdata[7:0];
            cfgBAct_r[7:6] <= pwdata[7:6]; // [RULE12]
            cfgBAct_r[1:0] <= pwdata[1:0]; // [RULE15]
          end
          `MMOC_ADDR_PHS: phsPre_r <= pwdata[7:0];
          `MMOC_ADDR_POL: pol_r <= pwdata[7:0];
          default: begin
          end
        endcase
      end
    end
  end

  // PWM pattern selection before and after demagnetization.
  always @* begin
    beforeD = !demag_r && !cfgA_r[`MMOC_A_SR]; // [RULE3]
    if (beforeD && cfgA_r[`MMOC_A_VC]) begin
      pat = cfgBAct_r[`MMOC_B_OS2] ? PAT_ODD : PAT_EVEN; // [RULE8] [RULE17]
    end else if (beforeD && cfgBAct_r[`MMOC_B_OS2]) begin
      pat = PAT_ALT; // [RULE17]
    end else begin
      pat = cfgBAct_r[1:0]; // [RULE16]
    end
    // Alternating code in voltage sensorless with top bit clear means no chopping.
    if (pat == PAT_ALT && !cfgA_r[`MMOC_A_VC] && !cfgA_r[`MMOC_A_SR] &&
        !cfgBAct_r[`MMOC_B_OS2]) begin
      pwmMask = 6'h00; // [RULE16]
    end else begin
      pwmMask = patMask(pat, pwmPhaseOdd);
    end
    if (direct) begin
      pwmMask = 6'h00; // [RULE7]
    end
    // Chopped channels go to their off level while the PWM level is low.
    pinNxt = ~(pol_r[5:0] ^ (phsAct_r[5:0] & ~(pwmMask & {6{!pwmLevel}}))); // [RULE20]
  end

  always @* begin
    case (paddr)
      `MMOC_ADDR_TIM: rdNxt = {24'h000000, commutationTimerCounter};
      `MMOC_ADDR_CMP: rdNxt = {24'h000000, cmp_r};
      `MMOC_ADDR_WGT: rdNxt = {24'h000000, wgt_r};
      `MMOC_ADDR_ZPRV: rdNxt = {24'h000000, zPrv_r};
      `MMOC_ADDR_ZCUR: rdNxt = {24'h000000, zCur_r};
      `MMOC_ADDR_CRA: rdNxt = {24'h000000, cfgA_r};
      `MMOC_ADDR_CRB: rdNxt = {24'h000000, cfgBAct_r}; // [RULE21]
      `MMOC_ADDR_PHS: rdNxt = {24'h000000, phsAct_r}; // [RULE21]
      `MMOC_ADDR_POL: rdNxt = {24'h000000, pol_r};
      `MMOC_ADDR_STS: rdNxt = {29'h00000000, demag_r, ctrlClockRun, currentComp};
      default: rdNxt = 32'h00000000;
    endcase
  end

  // Bus answer and registered outputs.
  always @(posedge clk) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      motorOutputPins <= 6'h00;
      motorOutputOe <= 6'h00;
      ctrlClockRun <= 1'b0;
      compInput <= 1'b0;
      currentComp <= 1'b0;
      referenceThresholdSelect <= 2'b00;
      zeroCrossEdgeSelect <= 1'b0;
      hwDemagEnable <= 1'b0;
      swDemagEnable <= 1'b0;
      filt_r <= 3'b000;
    end else begin
      pready <= psel && penable && !pready; // [RULE22]
      pslverr <= psel && penable && !pready && !addrOk; // [RULE22]
      if (rdEn && !pready) begin
        prdata <= rdNxt;
      end
      motorOutputPins <= pinNxt; // [RULE20]
      motorOutputOe <= gateOn ? 6'h3f : 6'h00; // [RULE1]
      ctrlClockRun <= gateOn && !direct; // [RULE1] [RULE5] [RULE6]
      case (phsAct_r[7:6])
        2'b00: compInput <= phaseInputA; // [RULE18]
        2'b01: compInput <= phaseInputB;
        2'b10: compInput <= phaseInputC;
        default: compInput <= 1'b0;
      endcase
      filt_r <= {filt_r[1:0], currentCompRaw};
      // Filter passes a level only after three equal samples.
      if (!cfgA_r[`MMOC_A_CFF]) begin
        currentComp <= currentCompRaw; // [RULE10]
      end else if (filt_r == 3'b111 || filt_r == 3'b000) begin
        currentComp <= filt_r[0]; // [RULE10]
      end
      referenceThresholdSelect <= cfgBAct_r[7:6]; // [RULE12]
      zeroCrossEdgeSelect <= cfgBAct_r[`MMOC_B_CPB]; // [RULE13]
      hwDemagEnable <= cfgBAct_r[`MMOC_B_HDM]; // [RULE14]
      swDemagEnable <= cfgBAct_r[`MMOC_B_SDM]; // [RULE14]
    end
  end

endmodule
